// [lasq_pkg.sv]
`default_nettype none
package lasq_pkg;
    // Reference clock used to pace the millisecond timers
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned MS_PS = 1000000000;
    localparam int unsigned MS_CYCLES = (MS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Timer bounds
    localparam int unsigned T1_MIN_SYM = 64;
    localparam int unsigned T1_MAX_SYM = 4000;
    localparam int unsigned TRN_DLY_MIN_MS = 100;
    localparam int unsigned TRN_DLY_MAX_LO_MS = 180;
    localparam int unsigned TRN_DLY_MAX_HI_MS = 600;
    localparam int unsigned RX_ALERT_MS = 30;
    localparam int unsigned T4_SYM = 210000;
    localparam int unsigned T5_SYM = 150000;
    localparam int unsigned T5_WARM_MS = 350;
    localparam int unsigned T6_LOW_SYM = 200000;
    localparam int unsigned T6_MID_SYM = 400000;
    localparam int unsigned T6_HIGH_SYM = 600000;
    localparam int unsigned T7_LOW_SYM = 180000;
    localparam int unsigned T7_MID_SYM = 360000;
    localparam int unsigned T7_HIGH_SYM = 540000;
    localparam int unsigned PRE_SYM = 1024;

    // Alerting sequence geometry
    localparam int unsigned PN_LEN = 63;
    localparam int unsigned WAKE_CYCLES = 60;
    localparam int unsigned WAKE_SYMS = PN_LEN * WAKE_CYCLES;
    localparam int unsigned TRL_N = 63;
    localparam int unsigned TRL_BITS = TRL_N + 5;
    localparam int unsigned TRL_TYPE_POS = 5;
    localparam logic [5:0] PN_SEED = 6'h01;

    // Scrambler tap masks, bit k-1 stands for x^k
    localparam logic [22:0] TAPS_DN = 23'h400010;
    localparam logic [22:0] TAPS_UP = 23'h420000;

    // Alerting symbols
    localparam int unsigned SYM_W = 2;
    localparam logic [1:0] SYM_ZERO = 2'h0;
    localparam logic [1:0] SYM_POS = 2'h1;
    localparam logic [1:0] SYM_NEG = 2'h3;
    localparam int unsigned FIFO_DEPTH = 4;

    localparam logic [1:0] BAND_LOW = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned MSC_W = 20;
    localparam int unsigned MS_W = 10;
    localparam int unsigned BIT_W = 7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RESP = 4'h1,
        ST_WAKE = 4'h3,
        ST_TRAIL = 4'h2,
        ST_WAIT_RPL = 4'h6,
        ST_WAIT_TRN = 4'h7,
        ST_TDLY = 4'h5,
        ST_TRAIN = 4'h4,
        ST_LOCK = 4'hc,
        ST_DATA = 4'hd
    } lasq_state_e;

    typedef enum logic [3:0] {
        SIG_SILENT = 4'h0,
        SIG_WAKEUP = 4'h1,
        SIG_TRAILER = 4'h2,
        SIG_TRAIN = 4'h3,
        SIG_COEFF = 4'h4,
        SIG_PRE = 4'h5,
        SIG_PRE_RESET = 4'h6,
        SIG_LOCKED = 4'h7,
        SIG_DATA = 4'h8
    } lasq_sig_e;
endpackage
`default_nettype wire

// [lasq_strm_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lasq_strm_if #(parameter int W = 2) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [lasq_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module lasq_fifo #(
    parameter int W = 2,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    lasq_strm_if.snk wr,
    lasq_strm_if.src rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } lasq_fifo_s;

    lasq_fifo_s r;
    lasq_fifo_s n;
    logic do_wr;
    logic do_rd;

    // Ready and valid fall with the clock enable so nothing moves while frozen
    assign wr.ready = ce_i && (r.cnt != FULL);
    assign rd.valid = ce_i && (r.cnt != '0);
    assign rd.data = r.mem[r.rp];

    always_comb begin
        n = r;
        do_wr = wr.valid && wr.ready;
        do_rd = rd.valid && rd.ready;
        if (do_wr) begin
            n.mem[r.wp] = wr.data;
            n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
        end
        if (do_rd) begin
            n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
        end
        case ({do_wr, do_rd})
            2'b10: n.cnt = r.cnt + 1'b1;
            2'b01: n.cnt = r.cnt - 1'b1;
            default: n.cnt = r.cnt;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= n;
        end
    end
endmodule // lasq_fifo
`default_nettype wire

// [lasq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module lasq_sequencer #(
    parameter int unsigned MS_CYC = lasq_pkg::MS_CYCLES,
    parameter int unsigned T4_SYMS = lasq_pkg::T4_SYM,
    parameter int unsigned T5_SYMS = lasq_pkg::T5_SYM,
    parameter int unsigned T6_LOW = lasq_pkg::T6_LOW_SYM,
    parameter int unsigned T6_MID = lasq_pkg::T6_MID_SYM,
    parameter int unsigned T6_HIGH = lasq_pkg::T6_HIGH_SYM,
    parameter int unsigned T7_LOW = lasq_pkg::T7_LOW_SYM,
    parameter int unsigned T7_MID = lasq_pkg::T7_MID_SYM,
    parameter int unsigned T7_HIGH = lasq_pkg::T7_HIGH_SYM,
    parameter int unsigned PRE_SYMS = lasq_pkg::PRE_SYM,
    parameter int unsigned DEPTH = lasq_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic role_net_i,
    input wire logic start_i,
    input wire logic warm_i,
    input wire logic [1:0] rate_band_i,
    input wire logic tick340_i,
    input wire logic tick85_i,
    input wire logic tick_neg_i,
    input wire logic rx_wakeup_det_i,
    input wire logic rx_train_det_i,
    input wire logic [lasq_pkg::TRL_BITS-1:0] trailer_i,
    output logic [lasq_pkg::SYM_W-1:0] tx_sym_o,
    output logic tx_sym_valid_o,
    input wire logic tx_sym_ready_i,
    output lasq_pkg::lasq_sig_e tx_sig_o,
    output logic [22:0] scram_taps_o,
    output logic scram_rst_o,
    output logic precoder_en_o,
    output logic trellis_en_o,
    output logic neg_constel_o,
    output logic zero_data_o,
    output logic coeff_start_o,
    output logic fec_frame_o,
    output logic fail_o,
    output logic active_o
);
    import lasq_pkg::*;

    typedef struct packed {
        lasq_state_e state;
        lasq_sig_e sig;
        logic [CNT_W-1:0] cnt;
        logic [MSC_W-1:0] msc;
        logic [MS_W-1:0] ms;
        logic [5:0] lfsr;
        logic [5:0] chip;
        logic [BIT_W-1:0] bit_idx;
        logic coeff_done;
        logic fec_done;
        logic srst;
        logic coeff;
        logic fec;
        logic fail;
        logic pre;
        logic trel;
        logic negc;
        logic zdata;
        logic [22:0] taps;
    } lasq_seq_s;

    localparam lasq_seq_s RST_VAL = '{state: ST_IDLE, sig: SIG_SILENT, lfsr: PN_SEED,
                                       taps: TAPS_UP, default: '0};

    lasq_seq_s r;
    lasq_seq_s n;
    logic jump;
    lasq_state_e dest;
    logic alert_tick;
    logic ms_tick;
    logic push;
    logic [SYM_W-1:0] sym;
    logic tbit;
    logic pn_step;
    logic [MS_W-1:0] dly_max;
    logic [CNT_W-1:0] t6;
    logic [CNT_W-1:0] t7;

    lasq_strm_if #(.W(SYM_W)) sym_in ();
    lasq_strm_if #(.W(SYM_W)) sym_out ();

    // Symbols queue here so a stalled line driver holds off the generator
    lasq_fifo #(.W(SYM_W), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .wr(sym_in.snk),
        .rd(sym_out.src)
    );

    assign sym_in.valid = push;
    assign sym_in.data = sym;
    assign tx_sym_o = sym_out.data;
    assign tx_sym_valid_o = sym_out.valid;
    assign sym_out.ready = tx_sym_ready_i;

    // Band-dependent limits
    always_comb begin
        dly_max = (rate_band_i == BAND_LOW) ? MS_W'(TRN_DLY_MAX_LO_MS) : MS_W'(TRN_DLY_MAX_HI_MS);
        case (rate_band_i)
            BAND_LOW: begin
                t6 = CNT_W'(T6_LOW);
                t7 = CNT_W'(T7_LOW);
            end
            BAND_MID: begin
                t6 = CNT_W'(T6_MID);
                t7 = CNT_W'(T7_MID);
            end
            default: begin
                t6 = CNT_W'(T6_HIGH);
                t7 = CNT_W'(T7_HIGH);
            end
        endcase
    end

    always_comb begin
        n = r;
        n.srst = 1'b0;
        n.coeff = 1'b0;
        n.fec = 1'b0;
        n.fail = 1'b0;
        jump = 1'b0;
        dest = r.state;
        push = 1'b0;
        pn_step = 1'b0;
        sym = SYM_ZERO;
        tbit = 1'b0;
        alert_tick = role_net_i ? tick340_i : tick85_i;
        ms_tick = (r.msc == MSC_W'(MS_CYC - 1));
        n.msc = ms_tick ? '0 : r.msc + 1'b1;
        if (ms_tick && (r.ms != '1)) begin
            n.ms = r.ms + 1'b1;
        end
        case (r.state)
            ST_IDLE: begin
                if (role_net_i && rx_wakeup_det_i) begin
                    jump = 1'b1;
                    dest = ST_RESP;
                end else if (!role_net_i && start_i) begin
                    jump = 1'b1;
                    dest = ST_WAKE;
                end
            end
            ST_RESP: begin
                // Reply at the earliest legal tick
                if (tick340_i) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == CNT_W'(T1_MIN_SYM - 1)) begin
                        jump = 1'b1;
                        dest = ST_WAKE;
                    end
                end
            end
            ST_WAKE: begin
                if (alert_tick && sym_in.ready) begin
                    push = 1'b1;
                    pn_step = 1'b1;
                    sym = r.lfsr[5] ? SYM_POS : SYM_NEG;
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == CNT_W'(WAKE_SYMS - 1)) begin
                        jump = 1'b1;
                        dest = ST_TRAIL;
                    end
                end
            end
            ST_TRAIL: begin
                tbit = (r.bit_idx == BIT_W'(TRL_TYPE_POS)) ? role_net_i : trailer_i[r.bit_idx];
                // One PN period per trailer bit
                if (alert_tick && sym_in.ready) begin
                    push = 1'b1;
                    pn_step = 1'b1;
                    sym = !tbit ? SYM_ZERO : (r.lfsr[5] ? SYM_POS : SYM_NEG);
                    n.chip = r.chip + 1'b1;
                    if (r.chip == 6'(PN_LEN - 1)) begin
                        n.chip = '0;
                        n.bit_idx = r.bit_idx + 1'b1;
                        if (r.bit_idx == BIT_W'(TRL_BITS - 1)) begin
                            jump = 1'b1;
                            dest = role_net_i ? ST_TDLY : ST_WAIT_RPL;
                        end
                    end
                end
            end
            ST_WAIT_RPL: begin
                if (rx_wakeup_det_i) begin
                    jump = 1'b1;
                    dest = ST_WAIT_TRN;
                end else if (tick340_i) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == CNT_W'(T1_MAX_SYM - 1)) begin
                        n.fail = 1'b1;
                        jump = 1'b1;
                        dest = ST_IDLE;
                    end
                end
            end
            ST_WAIT_TRN: begin
                if (rx_train_det_i) begin
                    jump = 1'b1;
                    dest = ST_TDLY;
                end else if (r.ms >= dly_max + MS_W'(RX_ALERT_MS)) begin
                    n.fail = 1'b1;
                    jump = 1'b1;
                    dest = ST_IDLE;
                end
            end
            ST_TDLY: begin
                // Hold the lower bound, well inside the upper
                if (ms_tick && (r.ms == MS_W'(TRN_DLY_MIN_MS - 1))) begin
                    jump = 1'b1;
                    dest = ST_TRAIN;
                end
            end
            ST_TRAIN: begin
                if (!role_net_i) begin
                    if (tick340_i) begin
                        n.cnt = r.cnt + 1'b1;
                    end
                    if (!r.coeff_done && (warm_i ?
                            (ms_tick && r.ms == MS_W'(T5_WARM_MS - 1)) :
                            (tick340_i && r.cnt == CNT_W'(T5_SYMS - 1)))) begin
                        n.coeff = 1'b1;
                        n.coeff_done = 1'b1;
                    end
                    if (tick340_i && (r.cnt == CNT_W'(T4_SYMS - 1))) begin
                        n.srst = 1'b1;
                        jump = 1'b1;
                        dest = ST_LOCK;
                    end
                end else if (rx_train_det_i) begin
                    jump = 1'b1;
                    dest = ST_LOCK;
                end else if (r.ms >= dly_max + MS_W'(RX_ALERT_MS)) begin
                    n.fail = 1'b1;
                    jump = 1'b1;
                    dest = ST_IDLE;
                end
            end
            ST_LOCK, ST_DATA: begin
                if (tick_neg_i && !r.fec_done) begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == t6 - 1'b1) begin
                        n.fec = 1'b1;
                        n.fec_done = 1'b1;
                    end
                end
                if ((r.state == ST_LOCK) && tick_neg_i && (r.cnt == t7 - 1'b1)) begin
                    n.state = ST_DATA;
                end
            end
            default: begin
                jump = 1'b1;
                dest = ST_IDLE;
            end
        endcase
        if (pn_step) begin
            n.lfsr = {r.lfsr[4:0], r.lfsr[5] ^ r.lfsr[4]};
        end
        if (jump) begin
            n.state = dest;
            n.cnt = '0;
            n.ms = '0;
            n.msc = '0;
            if (dest == ST_IDLE || dest == ST_TRAIN) begin
                n.lfsr = PN_SEED;
                n.chip = '0;
                n.bit_idx = '0;
                n.coeff_done = 1'b0;
                n.fec_done = 1'b0;
            end
        end
        case (n.state)
            ST_WAKE: n.sig = SIG_WAKEUP;
            ST_TRAIL: n.sig = SIG_TRAILER;
            ST_TRAIN: n.sig = n.coeff_done ? SIG_COEFF : SIG_TRAIN;
            // Precoded part of locking, reset form on customer side
            ST_LOCK: n.sig = (n.cnt >= CNT_W'(PRE_SYMS)) ? SIG_LOCKED :
                             (role_net_i ? SIG_PRE : SIG_PRE_RESET);
            ST_DATA: n.sig = SIG_DATA;
            default: n.sig = SIG_SILENT;
        endcase
        n.pre = (n.sig == SIG_PRE) || (n.sig == SIG_PRE_RESET) ||
                (n.sig == SIG_LOCKED) || (n.sig == SIG_DATA);
        n.trel = (n.sig == SIG_LOCKED) || (n.sig == SIG_DATA);
        n.negc = n.trel;
        n.zdata = (n.sig == SIG_LOCKED);
        n.taps = role_net_i ? TAPS_DN : TAPS_UP;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= RST_VAL;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign tx_sig_o = r.sig;
    assign scram_taps_o = r.taps;
    assign scram_rst_o = r.srst;
    assign precoder_en_o = r.pre;
    assign trellis_en_o = r.trel;
    assign neg_constel_o = r.negc;
    assign zero_data_o = r.zdata;
    assign coeff_start_o = r.coeff;
    assign fec_frame_o = r.fec;
    assign fail_o = r.fail;
    assign active_o = (r.state != ST_IDLE);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_resp_end;
        ce_i && (r.state == ST_RESP) && tick340_i && (r.cnt == CNT_W'(T1_MIN_SYM - 1));
    endsequence
    sequence s_dly_end;
        ce_i && (r.state == ST_TDLY) && ms_tick && (r.ms == MS_W'(TRN_DLY_MIN_MS - 1));
    endsequence
    sequence s_t4_end;
        ce_i && !role_net_i && (r.state == ST_TRAIN) && tick340_i &&
        (r.cnt == CNT_W'(T4_SYMS - 1));
    endsequence

    AST_LOCKED_UP: assert property (
        (r.sig == SIG_LOCKED) && !role_net_i |-> precoder_en_o && trellis_en_o &&
        zero_data_o && neg_constel_o && (scram_taps_o == TAPS_UP))
        else $error("upstream locked signal settings wrong");
    AST_LOCKED_DN: assert property (
        (r.sig == SIG_LOCKED) && role_net_i |-> precoder_en_o && trellis_en_o &&
        zero_data_o && (scram_taps_o == TAPS_DN))
        else $error("downstream locked signal settings wrong");
    AST_PRE_TRAIN: assert property (
        (r.sig == SIG_PRE) |-> precoder_en_o && !trellis_en_o && (scram_taps_o == TAPS_DN))
        else $error("precoded training settings wrong");
    AST_PRE_RESET: assert property (
        (r.sig == SIG_PRE_RESET) && ($past(r.sig) != SIG_PRE_RESET) |-> scram_rst_o &&
        precoder_en_o && !trellis_en_o)
        else $error("precoded reset training without scrambler reset");
    AST_RESP_WINDOW: assert property (
        s_resp_end |=> (r.state == ST_WAKE) && (r.sig == SIG_WAKEUP))
        else $error("network wake-up reply not at window start");
    AST_RESP_BOUND: assert property (
        (r.state == ST_RESP) |-> (r.cnt < CNT_W'(T1_MAX_SYM)))
        else $error("network reply window overrun");
    AST_TRAIN_DELAY: assert property (
        s_dly_end |=> (r.state == ST_TRAIN) ##1 (r.sig == SIG_TRAIN) [*2])
        else $error("training delay end not followed by training");
    AST_TDLY_MIN: assert property (
        (r.state == ST_TRAIN) && ($past(r.state) == ST_TDLY) |->
        ($past(r.ms) == MS_W'(TRN_DLY_MIN_MS - 1)))
        else $error("training started before lower bound");
    AST_SCR_RESET: assert property (
        s_t4_end |=> scram_rst_o && (r.state == ST_LOCK) && (r.sig == SIG_PRE_RESET))
        else $error("scrambler reset timer wrong");
    AST_COEFF: assert property (
        ce_i && !role_net_i && !warm_i && (r.state == ST_TRAIN) && !r.coeff_done &&
        tick340_i && (r.cnt == CNT_W'(T5_SYMS - 1)) |=> coeff_start_o)
        else $error("coefficient start missed");
    AST_FEC: assert property (
        fec_frame_o |-> ($past(r.cnt) == t6 - 1'b1) && (r.cnt == t6))
        else $error("code frame start off count");
    AST_LOCK_LEN: assert property (
        (r.state == ST_DATA) && ($past(r.state) == ST_LOCK) |->
        ($past(r.cnt) == t7 - 1'b1))
        else $error("code locking length wrong");
    AST_ALERT_TICK: assert property (
        push |-> (role_net_i ? tick340_i : tick85_i))
        else $error("alerting symbol on wrong clock");
    AST_NET_WAKE: assert property (
        ce_i && (r.state == ST_IDLE) && role_net_i && rx_wakeup_det_i |=>
        (r.state == ST_RESP))
        else $error("network ignored wake-up");
    AST_PN_NONZERO: assert property (
        (r.lfsr != 6'h00))
        else $error("wake-up generator stuck at zero");
    AST_TYPE_BIT: assert property (
        push && (r.state == ST_TRAIL) && (r.bit_idx == BIT_W'(TRL_TYPE_POS)) |->
        ((sym == SYM_ZERO) == !role_net_i))
        else $error("trailer type bit wrong");
    AST_FAIL_IDLE: assert property (
        fail_o |-> (r.state == ST_IDLE) && (tx_sig_o == SIG_SILENT))
        else $error("failure did not return to silence");
endmodule // lasq_sequencer
`default_nettype wire

// [lasq_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module lasq_far_end (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] sym_i,
    input wire logic valid_i,
    input wire logic [67:0] trl_i,
    output logic ready_o,
    output int cnt_o,
    output int bad_o
);
    import lasq_pkg::*;
    logic [5:0] pn;
    logic [2:0] ph;
    logic [1:0] f, e;
    int b;
    // Stall one cycle in eight
    assign ready_o = ph != 3'h7;
    // expected symbol
    // Sign judged against first chip, mapping polarity left open
    always_comb begin
        b = (cnt_o - int'(WAKE_SYMS)) / int'(PN_LEN);
        e = (cnt_o == 0) ? sym_i : f;
        if (pn[5]) begin
            e = 2'h0 - e;
        end
        if (cnt_o >= int'(WAKE_SYMS) && b < 68 && !trl_i[b]) begin
            e = SYM_ZERO;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pn <= PN_SEED;
            ph <= 3'h0;
            f <= SYM_ZERO;
            cnt_o <= 0;
            bad_o <= 0;
        end else begin
            ph <= ph + 3'h1;
            if (valid_i && ready_o) begin
                if (cnt_o == 0) begin
                    f <= sym_i;
                end
                if (sym_i !== e || (cnt_o == 0 && sym_i === SYM_ZERO)) begin
                    bad_o <= bad_o + 1;
                end
                cnt_o <= cnt_o + 1;
                pn <= {pn[4:0], pn[5] ^ pn[4]};
            end
        end
    end
endmodule // lasq_far_end
`default_nettype wire

// [lasq_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lasq_sequencer_tb;
    import lasq_pkg::*;
    logic clk_i = 0, nrst_i = 0, role = 0, start = 0, wdet = 0, tdet = 0, t340 = 0, t85 = 0;
    logic ce = 1, warm = 0, fast = 0;
    logic rdy, vld, pre, trel, zd, fec, fail, srst, negc, coeff, act;
    logic [1:0] sym, band = 2'h0;
    logic [22:0] taps;
    logic [67:0] trl = 68'h5a5c30f961e2d7b48, ex;
    lasq_sig_e sig;
    int cyc = 0, mismatches = 0, tests_run = 0, cnt, bad, c;
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        t340 <= !cyc[0];
        // Fast mode ticks every cycle so the FIFO fills and backpressure is exercised
        t85 <= fast || (cyc[1:0] == 2'h0);
    end
    lasq_sequencer #(.MS_CYC(2), .T4_SYMS(400), .T5_SYMS(20), .T6_LOW(60), .T7_LOW(50),
        .T6_MID(90), .T7_MID(70), .PRE_SYMS(8)) lasq_sequencer_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .role_net_i(role), .start_i(start),
        .warm_i(warm), .rate_band_i(band), .tick340_i(t340), .tick85_i(t85), .tick_neg_i(t340),
        .rx_wakeup_det_i(wdet), .rx_train_det_i(tdet), .trailer_i(trl), .tx_sym_o(sym),
        .tx_sym_valid_o(vld), .tx_sym_ready_i(rdy), .tx_sig_o(sig), .scram_taps_o(taps),
        .scram_rst_o(srst), .precoder_en_o(pre), .trellis_en_o(trel), .neg_constel_o(negc),
        .zero_data_o(zd), .coeff_start_o(coeff), .fec_frame_o(fec), .fail_o(fail),
        .active_o(act));
    lasq_far_end lasq_far_end_i (.clk_i(clk_i), .nrst_i(nrst_i), .sym_i(sym), .valid_i(vld),
        .trl_i(ex), .ready_o(rdy), .cnt_o(cnt), .bad_o(bad));
    task automatic chk(input string n, input int lo, input int hi, input logic [31:0] g);
        tests_run++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    // Codes below 9 wait for a signal kind, 9 for frame pulse, 10 for failure
    task automatic wt(input int k, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (!(k < 9 ? sig === lasq_sig_e'(k) : k == 9 ? fec === 1'b1 : fail === 1'b1)
            && n < 40000);
        if (n >= 40000) begin
            mismatches++;
            $display("[FAIL] wait %0d expected event seen timeout", k);
        end
    endtask
    task automatic rst(input logic r, input logic w, input logic f, input logic [1:0] b);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        role <= r;
        warm <= w;
        fast <= f;
        band <= b;
        ex <= {trl[67:6], r, trl[4:0]};
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
    endtask
    task automatic t_cust;
        rst(1'b0, 1'b0, 1'b1, 2'h0);
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        wt(1, c);
        chk("cust wakeup start", 0, 2, c);
        chk("cust taps", 32'h420000, 32'h420000, taps);
        wt(0, c);
        repeat (8) @(posedge clk_i);
        chk("cust symbols", 8064, 8064, cnt);
        chk("cust bad symbols", 0, 0, bad);
        wt(10, c);
        chk("cust reply timeout", 7984, 7998, c);
        chk("cust idle after fail", 0, 0, act);
        $display("customer test done");
    endtask
    task automatic t_net;
        rst(1'b1, 1'b0, 1'b0, 2'h0);
        @(posedge clk_i);
        wdet <= 1'b1;
        @(posedge clk_i);
        wdet <= 1'b0;
        wt(1, c);
        chk("net reply delay", 124, 130, c);
        chk("net taps", 32'h400010, 32'h400010, taps);
        wt(0, c);
        wt(3, c);
        chk("net train delay", 198, 202, c);
        chk("net symbols", 8064, 8064, cnt);
        chk("net bad symbols", 0, 0, bad);
        // Far training comes no sooner than its own 100 ms delay
        repeat (200) @(posedge clk_i);
        tdet <= 1'b1;
        @(posedge clk_i);
        tdet <= 1'b0;
        wt(5, c);
        chk("precoded start", 0, 2, c);
        wt(7, c);
        chk("precoded length", 13, 18, c);
        chk("locked flags", 7, 7, {pre, trel, zd});
        wt(8, c);
        chk("lock length", 80, 88, c);
        wt(9, c);
        chk("frame start", 17, 23, c);
        $display("network test done");
    endtask
    task automatic t_train(input logic w, input logic [1:0] b);
        rst(1'b0, w, w, b);
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        wt(1, c);
        wt(0, c);
        @(posedge clk_i);
        wdet <= 1'b1;
        @(posedge clk_i);
        wdet <= 1'b0;
        tdet <= 1'b1;
        @(posedge clk_i);
        tdet <= 1'b0;
        #1;
        chk("cust active", 1, 1, act);
        wt(3, c);
        chk("cust train delay", 198, 202, c);
        // Frozen clock enable must stretch the coefficient timer by 16 cycles
        @(posedge clk_i);
        ce <= 1'b0;
        repeat (16) @(posedge clk_i);
        ce <= 1'b1;
        wt(4, c);
        chk("coeff time", w ? 696 : 36, w ? 702 : 41, c);
        chk("coeff pulse", 1, 1, coeff);
        wt(6, c);
        chk("scrambler reset time", w ? 97 : 757, w ? 103 : 763, c);
        chk("scrambler reset pulse", 1, 1, srst);
        chk("cust reset taps", 32'h420000, 32'h420000, taps);
        wt(7, c);
        chk("cust locked flags", 15, 15, {pre, trel, zd, negc});
        wt(9, c);
        chk("cust frame start", b ? 162 : 102, b ? 166 : 106, c);
        chk("cust data signal", 8, 8, sig);
        $display("customer training test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        t_cust;
        t_net;
        t_train(1'b0, 2'h0);
        t_train(1'b1, 2'h1);
        report_and_stop;
    end
    initial begin
        #360us;
        mismatches++;
        report_and_stop;
    end
endmodule // lasq_sequencer_tb
`default_nettype wire
